/* core/swl_pkg.sv */
// constants and types for the single-wire sensor command link
package swl_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int NS_PER_US = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam logic [6:0] DIV_LAST = 7'(CYC_PER_US - 1);
  localparam logic [9:0] US_MAX = 10'h3FF;
  localparam logic [9:0] T_RESET_US = 10'h1E0;
  localparam logic [9:0] T_PRES_WAIT_US = 10'h01E;
  localparam logic [9:0] T_PRES_LOW_US = 10'h078;
  localparam logic [9:0] T_SLOT_US = 10'h01E;
  localparam logic [9:0] T_RECALL_US = 10'h00A;

  // ------------------------------------------------------------
  // commands and scratchpad
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_READ_SP = 8'hBE;
  localparam logic [7:0] CMD_WRITE_SP = 8'h4E;
  localparam logic [7:0] CMD_COPY_SP = 8'h48;
  localparam logic [7:0] NV_TO_SCRATCH_CMD = 8'hB8;
  localparam logic [3:0] SP_LAST_BYTE = 4'h8;
  localparam logic [3:0] WR_LAST_BYTE = 4'h2;
  localparam logic [3:0] SP_ALARM_BYTE = 4'h2;
  localparam logic [7:0] SP_RSV_VAL = 8'hFF;
  localparam logic [7:0] NV_UPPER_RST = 8'h00;
  localparam logic [7:0] NV_LOWER_RST = 8'h00;
  localparam logic [7:0] NV_CFG_RST = 8'h00;
  localparam int FIFO_W = 10;
  localparam int FIFO_D = 32;

  typedef enum logic [1:0] {LN_IDLE, LN_PWAIT, LN_PLOW} swl_line_t;
  typedef enum logic [2:0] {
    PH_NONE, PH_ROM, PH_FUNC, PH_WRITE, PH_READ, PH_CSTAT, PH_RSTAT
  } swl_phase_t;

endpackage

/* core/swl_link.sv */
// single-wire link slave with command decode and write-data FIFO
`timescale 1ns/1ps

// ------------------------------------------------------------
// write-data FIFO
// ------------------------------------------------------------
module swl_fifo #(
  parameter int W = 10,
  parameter int D = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic oValid;
    logic [W-1:0] oData;
  } swl_fifo_t;

  swl_fifo_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (s_r.oValid && outReady) begin
      s_nxt.oValid = 1'b0;
    end
    if (inValid && !s_r.full) begin
      s_nxt.mem[s_r.wp] = inData;
      s_nxt.wp = s_r.wp + 1'b1;
      s_nxt.cnt = s_nxt.cnt + 1'b1;
    end
    // output stage refills from the array so outputs stay registered
    if (!s_nxt.oValid && s_r.cnt != '0) begin
      s_nxt.oData = s_r.mem[s_r.rp];
      s_nxt.rp = s_r.rp + 1'b1;
      s_nxt.cnt = s_nxt.cnt - 1'b1;
      s_nxt.oValid = 1'b1;
    end
    s_nxt.full = (s_nxt.cnt == FULL_CNT);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign inReady = !s_r.full;
  assign outValid = s_r.oValid;
  assign outData = s_r.oData;
endmodule // swl_fifo

// ------------------------------------------------------------
// link slave
// ------------------------------------------------------------
module swl_link (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // open-drain data line
  input wire logic dqIn,
  output logic dqOut,
  output logic dqOe,
  // sensor side
  input wire logic [15:0] tempWord,
  input wire logic [7:0] crcByte,
  input wire logic convBusy,
  output logic convStart,
  output logic copyStart,
  output logic recallStart,
  // written bytes: {index, byte}
  output logic wrValid,
  input wire logic wrReady,
  output logic [swl_pkg::FIFO_W-1:0] wrData
);
  typedef struct packed {
    swl_pkg::swl_line_t line;
    swl_pkg::swl_phase_t phase;
    logic [6:0] div;
    logic [9:0] usCnt;
    logic [9:0] recallCnt;
    logic dqPrev;
    logic lowLong;
    logic inSlot;
    logic [7:0] shreg;
    logic [2:0] bitCnt;
    logic [3:0] byteCnt;
    logic [2:0][7:0] sp;
    logic [2:0][7:0] nv;
    logic pushPend;
    logic [swl_pkg::FIFO_W-1:0] pushData;
    logic oe;
    logic conv;
    logic copy;
    logic recall;
  } swl_state_t;

  swl_state_t s_r, s_nxt;
  logic fifoInReady;
  logic fall;
  logic rise;
  logic tick;
  logic txBit;
  logic [7:0] rxByte;

  // bit of the scratchpad image at byte idx, bit bi
  function automatic logic spBit(input logic [3:0] idx,
      input logic [2:0] bi, input logic [2:0][7:0] sp,
      input logic [15:0] t, input logic [7:0] crc);
    logic [7:0] b;
    b = swl_pkg::SP_RSV_VAL;
    unique case (idx)
      4'h0: b = t[7:0];
      4'h1: b = t[15:8];
      4'h2, 4'h3, 4'h4: b = sp[2'(idx - swl_pkg::SP_ALARM_BYTE)];
      4'h8: b = crc;
      default: b = swl_pkg::SP_RSV_VAL;
    endcase
    return b[bi];
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.dqPrev = dqIn;
    s_nxt.conv = 1'b0;
    s_nxt.copy = 1'b0;
    s_nxt.recall = 1'b0;
    fall = s_r.dqPrev && !dqIn;
    rise = !s_r.dqPrev && dqIn;
    tick = (s_r.div == swl_pkg::DIV_LAST);
    rxByte = {dqIn, s_r.shreg[7:1]};
    txBit = 1'b1;
    unique case (s_r.phase)
      swl_pkg::PH_READ: txBit = spBit(s_r.byteCnt, s_r.bitCnt, s_r.sp,
          tempWord, crcByte);
      swl_pkg::PH_CSTAT: txBit = !convBusy;
      swl_pkg::PH_RSTAT: txBit = (s_r.recallCnt == '0);
      default: txBit = 1'b1;
    endcase

    // ------------------------------------------------------------
    // microsecond time base
    // ------------------------------------------------------------
    s_nxt.div = tick ? '0 : s_r.div + 1'b1;
    if (tick && s_r.usCnt != swl_pkg::US_MAX) begin
      s_nxt.usCnt = s_r.usCnt + 1'b1;
    end
    if (tick && s_r.recallCnt != '0) begin
      s_nxt.recallCnt = s_r.recallCnt - 1'b1;
    end
    if (s_r.pushPend && fifoInReady) begin
      s_nxt.pushPend = 1'b0;
    end

    unique case (s_r.line)
      swl_pkg::LN_IDLE: begin
        if (fall) begin
          s_nxt.usCnt = '0;
          s_nxt.div = '0;
          s_nxt.inSlot = (s_r.phase != swl_pkg::PH_NONE);
          // drive zero for the first half of the slot only
          if (s_r.phase inside {swl_pkg::PH_READ, swl_pkg::PH_CSTAT,
              swl_pkg::PH_RSTAT} && !txBit) begin
            s_nxt.oe = 1'b1;
          end
        end else if (rise && s_r.lowLong) begin
          s_nxt.lowLong = 1'b0;
          s_nxt.line = swl_pkg::LN_PWAIT;
          s_nxt.usCnt = '0;
          s_nxt.div = '0;
        end else if (s_r.inSlot && s_r.usCnt == swl_pkg::T_SLOT_US) begin
          // one bit per slot, sampled or sent, then released
          s_nxt.inSlot = 1'b0;
          s_nxt.oe = 1'b0;
          s_nxt.bitCnt = s_r.bitCnt + 1'b1;
          if (s_r.phase inside {swl_pkg::PH_ROM, swl_pkg::PH_FUNC,
              swl_pkg::PH_WRITE}) begin
            s_nxt.shreg = rxByte;
          end
          if (s_r.bitCnt == 3'h7) begin
            unique case (s_r.phase)
              swl_pkg::PH_ROM: s_nxt.phase = swl_pkg::PH_FUNC;
              swl_pkg::PH_FUNC: begin
                s_nxt.byteCnt = '0;
                unique case (rxByte)
                  swl_pkg::CMD_CONVERT: begin
                    s_nxt.conv = 1'b1;
                    s_nxt.phase = swl_pkg::PH_CSTAT;
                  end
                  swl_pkg::CMD_READ_SP: begin
                    s_nxt.phase = swl_pkg::PH_READ;
                  end
                  swl_pkg::CMD_WRITE_SP: begin
                    s_nxt.phase = swl_pkg::PH_WRITE;
                  end
                  swl_pkg::CMD_COPY_SP: begin
                    s_nxt.nv = s_r.sp;
                    s_nxt.copy = 1'b1;
                    s_nxt.phase = swl_pkg::PH_NONE;
                  end
                  swl_pkg::NV_TO_SCRATCH_CMD: begin
                    s_nxt.sp = s_r.nv;
                    s_nxt.recall = 1'b1;
                    s_nxt.recallCnt = swl_pkg::T_RECALL_US;
                    s_nxt.phase = swl_pkg::PH_RSTAT;
                  end
                  default: s_nxt.phase = swl_pkg::PH_NONE;
                endcase
              end
              swl_pkg::PH_WRITE: begin
                // a byte still waiting for a full FIFO is overwritten
                s_nxt.sp[s_r.byteCnt[1:0]] = rxByte;
                s_nxt.pushPend = 1'b1;
                s_nxt.pushData = {s_r.byteCnt[1:0], rxByte};
                s_nxt.byteCnt = s_r.byteCnt + 1'b1;
                if (s_r.byteCnt == swl_pkg::WR_LAST_BYTE) begin
                  s_nxt.phase = swl_pkg::PH_NONE;
                end
              end
              swl_pkg::PH_READ: begin
                s_nxt.byteCnt = s_r.byteCnt + 1'b1;
                if (s_r.byteCnt == swl_pkg::SP_LAST_BYTE) begin
                  s_nxt.phase = swl_pkg::PH_NONE;
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
      swl_pkg::LN_PWAIT: begin
        if (s_r.usCnt == swl_pkg::T_PRES_WAIT_US) begin
          s_nxt.line = swl_pkg::LN_PLOW;
          s_nxt.oe = 1'b1;
          s_nxt.usCnt = '0;
          s_nxt.div = '0;
        end
      end
      swl_pkg::LN_PLOW: begin
        if (s_r.usCnt == swl_pkg::T_PRES_LOW_US) begin
          s_nxt.line = swl_pkg::LN_IDLE;
          s_nxt.oe = 1'b0;
          s_nxt.phase = swl_pkg::PH_ROM;
          s_nxt.bitCnt = '0;
        end
      end
    endcase

    // ------------------------------------------------------------
    // reset pulse detection, overrides any transfer
    // ------------------------------------------------------------
    if (!dqIn && !s_r.oe && !s_r.lowLong &&
        s_r.usCnt >= swl_pkg::T_RESET_US) begin
      s_nxt.lowLong = 1'b1;
      s_nxt.line = swl_pkg::LN_IDLE;
      s_nxt.phase = swl_pkg::PH_NONE;
      s_nxt.inSlot = 1'b0;
      s_nxt.bitCnt = '0;
      s_nxt.shreg = '0;
      s_nxt.oe = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.dqPrev <= 1'b1;
      s_r.sp <= {swl_pkg::NV_CFG_RST, swl_pkg::NV_LOWER_RST,
          swl_pkg::NV_UPPER_RST};
      s_r.nv <= {swl_pkg::NV_CFG_RST, swl_pkg::NV_LOWER_RST,
          swl_pkg::NV_UPPER_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  swl_fifo #(.W(swl_pkg::FIFO_W), .D(swl_pkg::FIFO_D)) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .inValid(s_r.pushPend),
    .inReady(fifoInReady),
    .inData(s_r.pushData),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(wrData)
  );

  assign dqOut = 1'b0;
  assign dqOe = s_r.oe;
  assign convStart = s_r.conv;
  assign copyStart = s_r.copy;
  assign recallStart = s_r.recall;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_PRES_WAIT: assert property (
    $rose(s_r.line == swl_pkg::LN_PLOW) |->
      $past(s_r.usCnt) == swl_pkg::T_PRES_WAIT_US && dqOe)
    else $error("presence started at wrong time");
  AST_PRES_LEN: assert property (
    $fell(s_r.line == swl_pkg::LN_PLOW) |->
      $past(s_r.usCnt) == swl_pkg::T_PRES_LOW_US && !dqOe)
    else $error("presence pulse length wrong");
  AST_RESET_DET: assert property (
    (!dqIn && !dqOe && !s_r.lowLong && s_r.usCnt >= swl_pkg::T_RESET_US)
      |=> s_r.phase == swl_pkg::PH_NONE && s_r.lowLong && !dqOe)
    else $error("long low did not reset link");
  AST_RX_SAMPLE: assert property (
    $changed(s_r.bitCnt) && $past(s_r.inSlot) |->
      $past(s_r.usCnt) == swl_pkg::T_SLOT_US)
    else $error("bit taken outside sampling point");
  AST_RD_WINDOW: assert property (
    dqOe && s_r.line == swl_pkg::LN_IDLE |->
      s_r.usCnt <= swl_pkg::T_SLOT_US && s_r.inSlot)
    else $error("read zero held past slot window");
  AST_RD_IN_SLOT: assert property (
    $rose(dqOe) && s_r.line == swl_pkg::LN_IDLE |->
      $past(s_r.dqPrev) && !$past(dqIn))
    else $error("device drove line without master slot");
  AST_CONV_STAT: assert property (
    $rose(dqOe) && s_r.phase == swl_pkg::PH_CSTAT |-> $past(convBusy))
    else $error("conversion status wrong");
  AST_CMD_ORDER: assert property (
    convStart || copyStart || recallStart |->
      $past(s_r.phase) == swl_pkg::PH_FUNC)
    else $error("function command without ROM command");
  AST_WRITE_PUSH: assert property (
    $rose(s_r.pushPend) |-> $past(s_r.phase) == swl_pkg::PH_WRITE)
    else $error("data pushed outside write command");
  AST_READ_END: assert property (
    s_r.phase == swl_pkg::PH_READ |-> s_r.byteCnt <= swl_pkg::SP_LAST_BYTE)
    else $error("scratchpad read past last byte");

  COV_PRESENCE: cover property ($fell(s_r.line == swl_pkg::LN_PLOW));
  COV_CONVERT: cover property (convStart);
  COV_WRITE: cover property (wrValid && wrReady);
  COV_READ_DONE: cover property (
    $fell(s_r.phase == swl_pkg::PH_READ) && !s_r.lowLong);
endmodule // swl_link

/* test/swl_master.sv */
// bus master model for the single-wire line
`timescale 1ns/1ps

module swl_master (
  // clock
  input wire logic mclk,
  // line
  input wire logic dqOe,
  output logic dqIn
);
  logic mLow = 1'b0;

  // pullup wins only when neither side pulls low
  assign dqIn = !(mLow || dqOe);

  task automatic hold(input int us);
    repeat (us * swl_pkg::CYC_PER_US) @(negedge mclk);
  endtask

  // reset pulse, then time the presence answer in us
  task automatic reset_pulse(output int waitUs, output int lowUs);
    int n;
    mLow = 1'b1;
    hold(490);
    mLow = 1'b0;
    n = 0;
    while (!dqOe && n < 30000) begin
      @(negedge mclk);
      n++;
    end
    waitUs = n / swl_pkg::CYC_PER_US;
    n = 0;
    while (dqOe && n < 30000) begin
      @(negedge mclk);
      n++;
    end
    lowUs = n / swl_pkg::CYC_PER_US;
    hold(20);
  endtask

  task automatic write_bit(input logic b);
    mLow = 1'b1;
    hold(b ? 5 : 62);
    mLow = 1'b0;
    hold(b ? 59 : 2);
  endtask

  task automatic read_bit(output logic b);
    mLow = 1'b1;
    hold(1);
    mLow = 1'b0;
    // sample at 13 us, well inside the 30 us valid window, for margin
    hold(12);
    b = dqIn;
    hold(49);
  endtask

  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) write_bit(v[i]);
  endtask

  task automatic read_byte(output logic [7:0] v);
    logic b;
    for (int i = 0; i < 8; i++) begin
      read_bit(b);
      v[i] = b;
    end
  endtask

  // reset, any ROM byte, then the function command
  task automatic open_cmd(input logic [7:0] cmd, output int w,
                          output int l);
    reset_pulse(w, l);
    write_byte(8'hCC);
    write_byte(cmd);
  endtask
endmodule // swl_master

/* test/single_wire_sensor_command_link_tb.sv */
// self-checking bench for the single-wire command link
`timescale 1ns/1ps

module single_wire_sensor_command_link_tb;
  logic mclk;
  logic resetn;
  logic dqIn;
  logic dqOut;
  logic dqOe;
  logic [15:0] tempWord;
  logic [7:0] crcByte;
  logic convBusy;
  logic convStart;
  logic copyStart;
  logic recallStart;
  logic wrValid;
  logic wrReady;
  logic [swl_pkg::FIFO_W-1:0] wrData;
  int bad_count = 0;
  int cmp_count = 0;
  int convCnt = 0;
  int copyCnt = 0;
  int recallCnt = 0;
  logic [7:0] wrBytes [3] = '{8'h5A, 8'hC3, 8'h1F};

  swl_link DUT (.mclk(mclk), .resetn(resetn), .dqIn(dqIn), .dqOut(dqOut),
    .dqOe(dqOe), .tempWord(tempWord), .crcByte(crcByte),
    .convBusy(convBusy), .convStart(convStart), .copyStart(copyStart),
    .recallStart(recallStart), .wrValid(wrValid), .wrReady(wrReady),
    .wrData(wrData));

  swl_master master (.mclk(mclk), .dqOe(dqOe), .dqIn(dqIn));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (convStart === 1'b1) convCnt++;
    if (copyStart === 1'b1) copyCnt++;
    if (recallStart === 1'b1) recallCnt++;
  end

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic open(input logic [7:0] cmd);
    int w;
    int l;
    master.open_cmd(cmd, w, l);
    check("presence wait", 16'(w >= 15 && w <= 60), 16'h1);
    check("presence low", 16'(l >= 60 && l <= 240), 16'h1);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_write;
    int n;
    open(swl_pkg::CMD_WRITE_SP);
    for (int k = 0; k < 3; k++) master.write_byte(wrBytes[k]);
    // user side stalled so far; drain one word at a time
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (wrValid !== 1'b1 && n < 1000) begin
        @(negedge mclk);
        n++;
      end
      check("write valid", 16'(wrValid), 16'h1);
      check("write data", 16'(wrData), {6'h00, 2'(k), wrBytes[k]});
      wrReady = 1'b1;
      @(negedge mclk);
      wrReady = 1'b0;
      @(negedge mclk);
    end
    repeat (4) @(negedge mclk);
    check("fifo empty", 16'(wrValid), 16'h0);
  endtask

  task automatic sc_read_abort;
    logic [7:0] v;
    logic [7:0] exp [5];
    exp = '{8'h3C, 8'hA5, 8'h5A, 8'hC3, 8'h1F};
    open(swl_pkg::CMD_READ_SP);
    for (int k = 0; k < 5; k++) begin
      master.read_byte(v);
      check("scratch byte", 16'(v), 16'(exp[k]));
    end
    // reset cuts the read short; a fresh read starts at byte 0
    open(swl_pkg::CMD_READ_SP);
    master.read_byte(v);
    check("restart byte", 16'(v), 16'h003C);
  endtask

  task automatic sc_convert;
    logic b;
    convBusy = 1'b1;
    open(swl_pkg::CMD_CONVERT);
    check("convert pulses", 16'(convCnt), 16'h0001);
    master.read_bit(b);
    check("busy status", 16'(b), 16'h0);
    convBusy = 1'b0;
    master.read_bit(b);
    check("done status", 16'(b), 16'h1);
  endtask

  task automatic sc_copy_recall;
    logic b;
    logic [7:0] v;
    open(swl_pkg::CMD_COPY_SP);
    check("copy pulses", 16'(copyCnt), 16'h0001);
    master.read_bit(b);
    check("line after copy", 16'(b), 16'h1);
    // clobber the scratchpad so only the recall can bring the bytes back
    open(swl_pkg::CMD_WRITE_SP);
    for (int k = 0; k < 3; k++) master.write_byte(8'h00);
    open(swl_pkg::NV_TO_SCRATCH_CMD);
    check("recall pulses", 16'(recallCnt), 16'h0001);
    master.read_bit(b);
    check("recall status", 16'(b), 16'h1);
    open(swl_pkg::CMD_READ_SP);
    for (int k = 0; k < 5; k++) begin
      master.read_byte(v);
      if (k >= 2) check("recalled byte", 16'(v), 16'(wrBytes[k-2]));
    end
  endtask

  task automatic sc_unknown;
    logic b;
    open(8'h00);
    master.read_bit(b);
    check("unknown idle", 16'(b), 16'h1);
    check("open drain value", 16'(dqOut), 16'h0);
    check("no pulses", 16'(convCnt + copyCnt + recallCnt), 16'h0003);
  endtask

  initial begin
    resetn = 1'b0;
    tempWord = 16'hA53C;
    crcByte = 8'h77;
    convBusy = 1'b0;
    wrReady = 1'b0;
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    repeat (5) @(negedge mclk);
    sc_write();
    sc_read_abort();
    sc_convert();
    sc_copy_recall();
    sc_unknown();
    close_out();
  end

  // the fixed 490us reset makes each session long
  initial begin
    repeat (4000000) @(posedge mclk);
    bad_count++;
    close_out();
  end
endmodule // single_wire_sensor_command_link_tb
